// ==== hw/apwb_port.sv ====
// Purpose: Device side of the parallel data port with word and byte modes.
// Assumes: Host strobes last several clk_i cycles; pins pass two flip-flops first.
// Notes: Written words are captured from the last sampled strobe-low cycle.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module apwb_port
	import apwb_pkg::*;
(
	input  wire logic                    clk_i,    // 50 MHz clock
	input  wire logic                    rst_i,    // Synchronous reset, active high
	input  wire logic [3:0]              adr_i,    // Wishbone byte address
	input  wire logic [31:0]             dat_i,    // Wishbone write data
	input  wire logic [3:0]              sel_i,    // Wishbone byte selects
	input  wire logic                    we_i,     // Wishbone write enable
	input  wire logic                    cyc_i,    // Wishbone cycle
	input  wire logic                    stb_i,    // Wishbone strobe
	output logic      [31:0]             dat_o,    // Wishbone read data
	output logic                         ack_o,    // Wishbone acknowledge
	input  wire apwb_pkg::apwb_pin_in_type  pins_i,   // Strobes, mode and data pin levels
	output apwb_pkg::apwb_pin_out_type      pins_o    // Data pin drive and enables
);
	import apwb_pkg::*;

	apwb_pin_in_type  sync1_r;
	apwb_pin_in_type  sync1_nxt;
	apwb_pin_in_type  sync2_r;
	apwb_pin_in_type  sync2_nxt;
	logic             ack_r;
	logic             ack_nxt;
	logic [31:0]      dat_r;
	logic [31:0]      dat_nxt;
	logic [11:0]      result_r;
	logic [11:0]      result_nxt;
	logic [2:0]       chan_r;
	logic [2:0]       chan_nxt;
	logic [11:0]      hostword_r;
	logic [11:0]      hostword_nxt;
	logic             new_r;
	logic             new_nxt;
	logic             pad_r;
	logic             pad_nxt;
	logic             wr_low_r;
	logic             wr_low_nxt;
	apwb_pin_in_type  cap_r;
	apwb_pin_in_type  cap_nxt;
	apwb_pin_out_type out_r;
	apwb_pin_out_type out_nxt;
	logic             rd_act;       // Synced select and read strobe both low
	logic             wr_act;       // Synced select and store strobe both low
	logic             commit;       // First synced cycle after a store strobe
	logic             word_mode;    // Synced mode pin, high for full width
	logic             high_byte_enable;         // Dual pin read as high byte pick
	logic             bus_wr;       // Wishbone write on its acknowledge edge
	logic             bus_rd;       // Wishbone read being answered
	logic             lo_commit;    // Check helper: low-byte store commits
	logic             hi_commit;    // Check helper: high-byte store commits

	// Two stages for every pin; only the second stage feeds logic.
	always_comb
	begin
		sync1_nxt = pins_i;
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, word_byte_select: 1'b1, data: 12'h000};
			sync2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, word_byte_select: 1'b1, data: 12'h000};
		end
		else
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	assign word_mode = sync2_r.word_byte_select;
	assign high_byte_enable      = ~word_mode & sync2_r.data[8];                   // RQ4
	assign rd_act    = ~sync2_r.cs_n & ~sync2_r.rd_n;                  // RQ10
	assign wr_act    = ~sync2_r.cs_n & ~sync2_r.wr_n;                  // RQ11
	assign commit    = wr_low_r & ~wr_act;
	// A write lands on the edge that sees ack high, the only edge a classic master commits on.
	assign bus_wr    = cyc_i & stb_i & we_i & ack_r;
	assign bus_rd    = cyc_i & stb_i & ~we_i & ~ack_r;

	// Pin drive: floating unless a read is in progress.
	always_comb
	begin
		out_nxt = '{data: 12'h000, oe: 12'h000};                          // RQ1
		if (rd_act)
		begin
			if (word_mode)
			begin
				out_nxt.data = result_r;                                      // RQ2
				out_nxt.oe   = 12'hfff;                                       // RQ3 RQ9
			end
			else if (high_byte_enable)
			begin
				out_nxt.data[3:0] = result_r[11:8];                           // RQ6
				out_nxt.data[6:4] = chan_r;                                   // RQ7
				out_nxt.oe        = 12'h0ff;
			end
			else
			begin
				out_nxt.data[7:0] = result_r[7:0];                            // RQ5
				out_nxt.oe        = 12'h0ff;
			end
		end
	end

	// Host writes: keep the last strobe-low sample, commit on strobe release.
	always_comb
	begin
		wr_low_nxt   = wr_act;
		cap_nxt      = wr_act ? sync2_r : cap_r;
		hostword_nxt = hostword_r;
		new_nxt      = new_r;
		pad_nxt      = pad_r;
		if (bus_wr && adr_i == ADDR_HOSTWORD && sel_i[2])
		begin
			new_nxt = new_r & ~dat_i[HW_NEW_POS];
			pad_nxt = pad_r & ~dat_i[HW_PAD_POS];
		end
		// Hardware set follows the software clear so a coinciding event is kept.
		if (commit)
		begin
			if (cap_r.word_byte_select)
			begin
				hostword_nxt = cap_r.data;                                    // RQ2 RQ9
				new_nxt      = 1'b1;
			end
			else if (cap_r.data[8])
			begin
				// Second access of a byte pair completes the word.
				hostword_nxt[11:8] = cap_r.data[3:0];                         // RQ6 RQ12
				new_nxt            = 1'b1;
				if (cap_r.data[7:4] != 4'h0)
					pad_nxt = 1'b1;                                           // RQ8
			end
			else
				hostword_nxt[7:0] = cap_r.data[7:0];                          // RQ5
		end
	end

	// Result source: software loads the word and channel tag that a pin read returns.
	// Reads see this register live, so a load during a host read changes the lines mid-strobe.
	always_comb
	begin
		result_nxt = result_r;
		chan_nxt   = chan_r;
		if (bus_wr && adr_i == ADDR_RESULT)
		begin
			if (sel_i[0])
			begin
				result_nxt[7:0] = dat_i[7:0];
			end
			if (sel_i[1])
			begin
				result_nxt[11:8] = dat_i[11:8];
				chan_nxt         = dat_i[RES_CHAN_POS +: CHAN_W];
			end
		end
	end

	// Wishbone slave: one wait state, unmapped reads return zero.
	always_comb
	begin
		ack_nxt = cyc_i & stb_i & ~ack_r;
		dat_nxt = 32'h0000_0000;
		if (bus_rd)
		begin
			unique case (adr_i)
				ADDR_RESULT:   dat_nxt = {17'h00000, chan_r, result_r};
				ADDR_HOSTWORD: dat_nxt = {14'h0000, pad_r, new_r, 4'h0, hostword_r};
				ADDR_STATUS:   dat_nxt = {30'h0000_0000, rd_act, word_mode};
				default:       dat_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Wishbone answer registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// Result source registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			result_r <= RESULT_RESET;
			chan_r   <= CHAN_RESET;
		end
		else
		begin
			result_r <= result_nxt;
			chan_r   <= chan_nxt;
		end
	end

	// Host-write capture registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hostword_r <= HOSTWORD_RESET;
			new_r      <= 1'b0;
			pad_r      <= 1'b0;
			wr_low_r   <= 1'b0;
			cap_r      <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, word_byte_select: 1'b1, data: 12'h000};
		end
		else
		begin
			hostword_r <= hostword_nxt;
			new_r      <= new_nxt;
			pad_r      <= pad_nxt;
			wr_low_r   <= wr_low_nxt;
			cap_r      <= cap_nxt;
		end
	end

	// Pin drive registers; the lines follow the synced strobes by one edge.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_r <= '{data: 12'h000, oe: 12'h000};
		end
		else
		begin
			out_r <= out_nxt;
		end
	end

	assign ack_o  = ack_r;
	assign dat_o  = dat_r;
	assign pins_o = out_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	idle_float_a: assert property (!rd_act |=> pins_o.oe == 12'h000) // RQ1
		else $error("Data pins driven without a read strobe.");
	read_drive_a: assert property (rd_act |=> pins_o.oe[7:0] == 8'hff) // RQ10
		else $error("Low lines not driven during a read.");
	word_upper_a: assert property (rd_act && word_mode |=> pins_o.oe[11:8] == 4'hf) // RQ9
		else $error("Upper lines or bit 8 not driven in word mode read.");
	byte_pick_a: assert property (!word_mode |=> pins_o.oe[11:8] == 4'h0) // RQ4
		else $error("Dual pin or upper lines driven in byte mode.");
	low_byte_a: assert property (rd_act && !word_mode && !high_byte_enable |=> pins_o.data[7:0] == $past(result_r[7:0])) // RQ5
		else $error("Low byte read carries wrong data.");
	high_byte_a: assert property (rd_act && high_byte_enable |=> pins_o.data[7:0] == {1'b0, $past(chan_r), $past(result_r[11:8])}) // RQ7
		else $error("High byte read carries wrong bits or channel tag.");
	word_store_a: assert property (commit && cap_r.word_byte_select |=> hostword_r == $past(cap_r.data) && new_r) // RQ11
		else $error("Word-mode write not captured.");
	pad_flag_a: assert property (commit && !cap_r.word_byte_select && cap_r.data[8] && cap_r.data[7:4] != 4'h0 |=> pad_r) // RQ8
		else $error("Nonzero pad bits not flagged.");
	bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("Wishbone acknowledge not a single cycle after one wait.");

	// Helpers for the checks below; they feed no logic.
	assign lo_commit = commit & ~cap_r.word_byte_select & ~cap_r.data[8];
	assign hi_commit = commit & ~cap_r.word_byte_select & cap_r.data[8];

	data_quiet_a: assert property (!rd_act |=> pins_o.data == 12'h000) // RQ1
		else $error("Drive value left on the lines outside a read.");
	word_data_a: assert property (rd_act && word_mode |=> pins_o.data == $past(result_r)) // RQ2
		else $error("Word read carries the wrong result.");
	pin8_data_a: assert property (rd_act && word_mode // RQ3
		|=> pins_o.oe[8] && pins_o.data[8] == $past(result_r[8]))
		else $error("Dual pin does not carry result bit 8 in word mode.");
	byte_lane_a: assert property (rd_act && !word_mode |=> pins_o.oe == 12'h0ff) // RQ5
		else $error("Byte read does not drive exactly the low lines.");
	upper_quiet_a: assert property (!word_mode |=> pins_o.data[11:8] == 4'h0) // RQ4
		else $error("Drive value on the dual pin or upper lines in byte mode.");
	high_top_a: assert property (rd_act && high_byte_enable |=> pins_o.data[3:0] == $past(result_r[11:8])) // RQ6
		else $error("High byte read does not carry the top four bits.");
	chan_tag_a: assert property (rd_act && high_byte_enable // RQ7
		|=> pins_o.data[6:4] == $past(chan_r) && !pins_o.data[7])
		else $error("High byte read carries a wrong channel tag.");
	lo_store_a: assert property (lo_commit |=> hostword_r[7:0] == $past(cap_r.data[7:0])) // RQ5
		else $error("Low byte write not stored.");
	hi_store_a: assert property (hi_commit |=> hostword_r[11:8] == $past(cap_r.data[3:0]) && new_r) // RQ6
		else $error("High byte write not stored.");
	pair_keep_a: assert property (hi_commit |=> hostword_r[7:0] == $past(hostword_r[7:0])) // RQ12
		else $error("High byte write disturbed the low byte.");
	low_keep_a: assert property (lo_commit |=> hostword_r[11:8] == $past(hostword_r[11:8])) // RQ12
		else $error("Low byte write disturbed the top bits.");
	word_hold_a: assert property (!commit |=> hostword_r == $past(hostword_r)) // RQ2
		else $error("Host word changed without a host write.");
	commit_pulse_a: assert property (commit |=> !commit) // RQ11
		else $error("One host write committed twice.");
	new_clear_a: assert property (bus_wr && adr_i == ADDR_HOSTWORD && sel_i[2]
		&& dat_i[HW_NEW_POS] && !commit |=> !new_r)
		else $error("New flag not cleared by software.");
	pad_clear_a: assert property (bus_wr && adr_i == ADDR_HOSTWORD && sel_i[2] // RQ8
		&& dat_i[HW_PAD_POS] && !commit |=> !pad_r)
		else $error("Pad flag not cleared by software.");
	result_hold_a: assert property (!(bus_wr && adr_i == ADDR_RESULT) // RQ2
		|=> result_r == $past(result_r) && chan_r == $past(chan_r))
		else $error("Result source changed without a bus write.");
	write_on_ack_a: assert property (cyc_i && stb_i && we_i && !ack_o |=> result_r == $past(result_r))
		else $error("Bus write landed before its acknowledge.");
	result_read_a: assert property (bus_rd && adr_i == ADDR_RESULT // RQ2
		|=> dat_o == {17'h00000, $past(chan_r), $past(result_r)})
		else $error("Result register read returns wrong data.");
	status_read_a: assert property (bus_rd && adr_i == ADDR_STATUS // RQ3
		|=> dat_o == {30'h0000_0000, $past(rd_act), $past(word_mode)})
		else $error("Status read returns wrong data.");
	unmapped_zero_a: assert property (bus_rd && adr_i != ADDR_RESULT && adr_i != ADDR_HOSTWORD
		&& adr_i != ADDR_STATUS |=> dat_o == 32'h0000_0000)
		else $error("Unmapped read returns nonzero data.");
endmodule : apwb_port

// ==== hw/apwb_pkg.sv ====
// Purpose: Constants and carriers for the converter parallel host data port.
// Assumes: 50 MHz clk_i; pins arrive asynchronously and are synchronised in the port.
// Notes: Wishbone register map for the result source and host-write capture.
// How it works
// [RQ1] Data pins float unless strobes direct otherwise.
// [RQ2] Same pins return results and take writes.
// [RQ3] Word mode: dual pin is data bit 8.
// [RQ4] Byte mode: dual pin selects high byte.
// [RQ5] Low byte travels on the low lines.
// [RQ6] High byte: top four bits on lines 0-3.
// [RQ7] High byte read: channel tag on lines 4-6.
// [RQ8] High byte write: host zeroes lines 4-7.
// [RQ9] Word mode: upper lines carry bits 9-11.
// [RQ10] Result driven after read strobe with select.
// [RQ11] Host writes with store strobe and select.
// [RQ12] Byte mode needs two accesses per word.
package apwb_pkg;
	localparam int          DATA_W          = 12;
	localparam int          CHAN_W          = 3;
	localparam logic [3:0]  ADDR_RESULT     = 4'h0;
	localparam logic [3:0]  ADDR_HOSTWORD   = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h8;
	localparam int          RES_CHAN_POS    = 12;
	localparam int          HW_NEW_POS      = 16;
	localparam int          HW_PAD_POS      = 17;
	localparam int          ST_WORD_POS     = 0;
	localparam int          ST_READ_POS     = 1;
	localparam logic [11:0] RESULT_RESET    = 12'h000;
	localparam logic [2:0]  CHAN_RESET      = 3'h0;
	localparam logic [11:0] HOSTWORD_RESET  = 12'h000;

	typedef struct packed {
		logic              cs_n;
		logic              rd_n;
		logic              wr_n;
		logic              word_byte_select;
		logic [DATA_W-1:0] data;
	} apwb_pin_in_type;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] oe;
	} apwb_pin_out_type;
endpackage : apwb_pkg

// ==== sim/apwb_host_model.sv ====
// Purpose: Host bus master model driving the data port pins.
// Assumes: Strobes held six cycles so the port's synchronisers see them.
// Notes: Released lines show the inverse of their last value, never a stale copy.
`timescale 1ns/1ps
module apwb_host_model
	import apwb_pkg::*;
(
	input  wire logic             clk_i,  // Port clock
	input  wire apwb_pin_out_type pins_o, // Device drive
	output apwb_pin_in_type       pins_i  // Resolved pin levels
);
	logic        cs_n_r, rd_n_r, wr_n_r, word_r;
	logic [11:0] hd_r, hoe_r;
	initial
	begin
		{cs_n_r, rd_n_r, wr_n_r, word_r} = 4'hf;
		hd_r = 12'h000;
		hoe_r = 12'h000;
	end
	always_comb
	begin
		pins_i.cs_n = cs_n_r;
		pins_i.rd_n = rd_n_r;
		pins_i.wr_n = wr_n_r;
		pins_i.word_byte_select = word_r;
		pins_i.data = (pins_o.oe & pins_o.data) | (~pins_o.oe & ~(hd_r ^ hoe_r));
	end
	task automatic acc(input logic w, input logic wd, input logic hb, input logic [11:0] d, output logic [11:0] q);
		@(posedge clk_i);
		cs_n_r <= 1'b0;
		rd_n_r <= w;
		wr_n_r <= !w;
		word_r <= wd;
		hd_r <= wd ? d : {d[11:9], hb, d[7:0]};
		hoe_r <= w ? 12'hfff : (wd ? 12'h000 : 12'h100);
		repeat (6) @(posedge clk_i);
		q = pins_i.data;
		{cs_n_r, rd_n_r, wr_n_r} <= 3'h7;
		repeat (6) @(posedge clk_i);
		hoe_r <= wd ? 12'h000 : 12'h100;
	endtask : acc
endmodule : apwb_host_model

// ==== sim/adc_parallel_word_byte_port_tb_top.sv ====
// Purpose: Self-checking bench for the parallel data port.
// Assumes: Wishbone answers one cycle after a request is taken.
// Notes: Byte-mode reads compare only the low lines; the host drives the dual pin and the rest float.
`timescale 1ns/1ps
module adc_parallel_word_byte_port_tb_top;
	import apwb_pkg::*;
	logic             clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
	logic [3:0]       adr_i, sel_i;
	logic [31:0]      dat_i, dat_o, q;
	logic [11:0]      p;
	apwb_pin_in_type  pins_i;
	apwb_pin_out_type pins_o;
	int               n_mismatch, checked, ncyc;
	apwb_port uut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .pins_i, .pins_o);
	apwb_host_model host (.clk_i, .pins_o, .pins_i);
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb
	always @(posedge clk_i)
	begin
		ncyc++;
		if (ncyc == 2000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {1'b1, 43'h0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(32'(pins_o.oe), 32'h0);
		wb(1'b1, 4'h0, 32'h5a5c, 4'h3);
		wb(1'b0, 4'h8, 32'h0, 4'hf);
		chk(q, 32'h1);
		fork
			host.acc(1'b0, 1'b1, 1'b0, 12'h000, p);
			begin
				repeat (5) @(posedge clk_i);
				wb(1'b0, 4'h8, 32'h0, 4'hf);
			end
		join
		chk(q, 32'h3);
		chk(32'(p), 32'ha5c);
		chk(32'(pins_o.oe), 32'h0);
		host.acc(1'b0, 1'b0, 1'b0, 12'h000, p);
		chk(32'(p[7:0]), 32'h5c);
		host.acc(1'b0, 1'b0, 1'b1, 12'h000, p);
		chk(32'(p[7:0]), 32'h5a);
		host.acc(1'b1, 1'b1, 1'b0, 12'h3c7, p);
		wb(1'b0, 4'h4, 32'h0, 4'hf);
		chk(q, 32'h103c7);
		wb(1'b1, 4'h4, 32'h30000, 4'h4);
		wb(1'b0, 4'h4, 32'h0, 4'hf);
		chk(q, 32'h3c7);
		host.acc(1'b1, 1'b0, 1'b0, 12'h09e, p);
		host.acc(1'b1, 1'b0, 1'b1, 12'h006, p);
		wb(1'b0, 4'h4, 32'h0, 4'hf);
		chk(q, 32'h1069e);
		host.acc(1'b1, 1'b0, 1'b1, 12'h0f2, p);
		wb(1'b0, 4'h4, 32'h0, 4'hf);
		chk(q, 32'h3029e);
		wb(1'b0, 4'h8, 32'h0, 4'hf);
		chk(q, 32'h0);
		wb(1'b0, 4'hc, 32'h0, 4'hf);
		chk(q, 32'h0);
		give_verdict();
	end
endmodule : adc_parallel_word_byte_port_tb_top
